// ===== hw/aoc_pkg.sv
// ****************************************************************
// Output configuration constants
// ****************************************************************
package aoc_pkg;

    // Byte offsets of the register words
    localparam logic [7:0] ID_BASE = 8'h00;
    localparam logic [7:0] PROTO_BASE = 8'h0C;
    localparam logic [7:0] CONTENT_BASE = 8'h10;

    // Writable bits; everything else reads zero
    localparam logic [31:0] ID_WMASK = 32'h000F_0000;
    localparam logic [31:0] PROTO_WMASK = 32'h0000_1343;
    localparam logic [31:0] CONTENT_WMASK = 32'h0000_7000;

    // Values after reset
    localparam logic [31:0] ID_RST = 32'h0001_0000;
    localparam logic [31:0] PROTO_RST = 32'h0000_0000;
    localparam logic [31:0] CONTENT_RST = 32'h0000_0000;

    // Field positions
    localparam int unsigned GPO_BIT = 12;
    localparam int unsigned LANE_LSB = 8;
    localparam int unsigned SYNC_SRC_BIT = 6;
    localparam int unsigned PROTO_LSB = 0;
    localparam int unsigned CHAIN_APPEND_BIT = 14;
    localparam int unsigned SUPPLY_LSB = 12;
    localparam int unsigned CHAIN_ID_LSB = 16;

    // Frame geometry
    localparam int unsigned RESULT_W = 16;
    localparam int unsigned CHAIN_W = 4;
    localparam int unsigned FRAME_W = 32;
    localparam int unsigned LEN_W = 6;

    // Output protocol code for controller-clock / source-synchronous
    localparam logic [1:0] PROTO_SYNC = 2'h3;

    // Second lane function
    typedef enum logic [1:0] {
        LANE_OFF,
        LANE_ALARM,
        LANE_GPO,
        LANE_DATA
    } aoc_lane_e;

endpackage : aoc_pkg

// ===== hw/aoc_frame_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Frame hand-over from register side to a lane serializer
// ****************************************************************
interface aoc_frame_if;
    logic [31:0] word;
    logic [5:0] len;
    logic twoLane;
    logic fallLaunch;
    logic req;
    logic ack;

    // Word fields are held stable while req differs from ack
    modport src (
        output word,
        output len,
        output twoLane,
        output fallLaunch,
        output req,
        input ack
    );
    modport snk (
        input word,
        input len,
        input twoLane,
        input fallLaunch,
        input req,
        output ack
    );
endinterface : aoc_frame_if

// ===== hw/aoc_lane_serializer.sv
`timescale 1ns/1ps
// ****************************************************************
// Lane serializer, runs on whichever clock shifts the frame
// ****************************************************************
module aoc_lane_serializer #(
    parameter bit SYNC_SEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic frameSelN,
    aoc_frame_if.snk fi,
    output logic laneA,
    output logic laneB,
    output logic laneOe
);
    logic [1:0] reqSync_q, reqSync_d, selSync_q, selSync_d;
    logic ack_q, ack_d, started_q, started_d;
    logic [31:0] pendWord_q, pendWord_d, shift_q, shift_d;
    logic [5:0] pendLen_q, pendLen_d, len_q, len_d, cnt_q, cnt_d;
    logic pendTwo_q, pendTwo_d, two_q, two_d;
    logic pendFall_q, pendFall_d, fall_q, fall_d;
    logic riseA_q, riseA_d, riseB_q, riseB_d, riseOe_q, riseOe_d;
    logic fallA_q, fallB_q, fallOe_q;
    logic selN;
    logic [5:0] step;

    // Frame select from the internal clock side is a foreign pin
    assign selN = SYNC_SEL ? selSync_q[1] : frameSelN;
    assign step = two_q ? 6'h02 : 6'h01;
    assign fi.ack = ack_q;

    // Next state: take new word, then shift one or two bits a clock
    always_comb begin
        reqSync_d = {reqSync_q[0], fi.req};
        selSync_d = {selSync_q[0], frameSelN};
        ack_d = ack_q;
        pendWord_d = pendWord_q;
        pendLen_d = pendLen_q;
        pendTwo_d = pendTwo_q;
        pendFall_d = pendFall_q;
        shift_d = shift_q;
        len_d = len_q;
        two_d = two_q;
        fall_d = fall_q;
        cnt_d = cnt_q;
        started_d = started_q;
        if (reqSync_q[1] != ack_q) begin
            pendWord_d = fi.word;
            pendLen_d = fi.len;
            pendTwo_d = fi.twoLane;
            pendFall_d = fi.fallLaunch;
            ack_d = ~ack_q;
        end
        if (selN) begin
            // Deselected: preload so the first bit stands at select
            started_d = 1'b0;
            shift_d = pendWord_q;
            len_d = pendLen_q;
            two_d = pendTwo_q;
            fall_d = pendFall_q;
            cnt_d = 6'h00;
        end else if (!started_q && !fall_q) begin
            // Rising launch: first edge only holds the preloaded bit
            started_d = 1'b1;
        end else begin
            // Shift: falling launch from the first edge, as its first bit stood since select; rising launch from the second edge
            started_d = 1'b1;
            shift_d = two_q ? {shift_q[29:0], 2'b00}
                            : {shift_q[30:0], 1'b0};
            cnt_d = cnt_q + step;
        end
        riseA_d = shift_d[31];
        riseB_d = shift_d[30];
        riseOe_d = !selN && (cnt_d < len_d);
    end

    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqSync_q <= 2'b00;
            selSync_q <= 2'b11;
            ack_q <= 1'b0;
            pendWord_q <= 32'h0000_0000;
            pendLen_q <= 6'h00;
            pendTwo_q <= 1'b0;
            pendFall_q <= 1'b0;
            shift_q <= 32'h0000_0000;
            len_q <= 6'h00;
            two_q <= 1'b0;
            fall_q <= 1'b0;
            cnt_q <= 6'h00;
            started_q <= 1'b0;
            riseA_q <= 1'b0;
            riseB_q <= 1'b0;
            riseOe_q <= 1'b0;
        end else if (ce) begin
            reqSync_q <= reqSync_d;
            selSync_q <= selSync_d;
            ack_q <= ack_d;
            pendWord_q <= pendWord_d;
            pendLen_q <= pendLen_d;
            pendTwo_q <= pendTwo_d;
            pendFall_q <= pendFall_d;
            shift_q <= shift_d;
            len_q <= len_d;
            two_q <= two_d;
            fall_q <= fall_d;
            cnt_q <= cnt_d;
            started_q <= started_d;
            riseA_q <= riseA_d;
            riseB_q <= riseB_d;
            riseOe_q <= riseOe_d;
        end
    end

    // Half-cycle retime for modes that launch on the falling edge
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            fallA_q <= 1'b0;
            fallB_q <= 1'b0;
            fallOe_q <= 1'b0;
        end else if (ce) begin
            fallA_q <= riseA_q;
            fallB_q <= riseB_q;
            fallOe_q <= riseOe_q;
        end
    end

    assign laneA = fall_q ? fallA_q : riseA_q;
    assign laneB = fall_q ? fallB_q : riseB_q;
    assign laneOe = fall_q ? fallOe_q : riseOe_q;

    property p_twoBitStep;
        @(posedge clk) disable iff (rst)
        ce && !selN && started_q && two_q
            |=> cnt_q == $past(cnt_q) + 6'h02;
    endproperty
    a_twoBitStep: assert property (p_twoBitStep)
        else $error("two-lane frame did not advance two bits");

    property p_ackAnswers;
        @(posedge clk) disable iff (rst)
        ce && $changed(reqSync_q[1]) ##1 ce |=> ack_q == reqSync_q[1];
    endproperty
    a_ackAnswers: assert property (p_ackAnswers)
        else $error("frame request not acknowledged");

endmodule : aoc_lane_serializer

// ===== hw/aoc_output_config_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Output-protocol register bytes sit at byte addresses 0Ch to 0Fh.
// - Output-content register bytes sit at byte addresses 10h to 13h.
// - General output pin follows the stored general output level bit.
// - Lane function 00b: second lane high impedance, single-lane data.
// - Lane function 01b: second lane carries the alarm indication.
// - Lane function 10b: second lane is the general purpose output.
// - Lane function 11b: data on both lanes, two bits a clock.
// - Sync source bit: 0 shifts on host clock, 1 on internal clock.
// - Sync source bit matters only with output protocol 11b.
// - Output protocol 0xb follows input SPI mode; host never writes 10b.
// - Output protocol 11b uses controller-clock or source-synchronous.
// - Reserved bits of both registers read as zero.
// - Chain id append bit adds the 4-bit chain id to frames.
// - Supply alarm field appends none, high, low or both flags.
// - Input protocol picks SPI clock polarity and phase.
// - Writable 4-bit chain id resets to 0001b.
module aoc_output_config_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic linkClk,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [1:0] inputProtocolSelect,
    input wire logic [15:0] convData,
    input wire logic convValid,
    input wire logic alarmActive,
    input wire logic supplyHigh,
    input wire logic supplyLow,
    input wire logic frameSelN,
    output logic serialOutLaneA,
    output logic serialOutLaneAOe,
    output logic serialOutLaneB,
    output logic serialOutLaneBOe
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Byte lane write limited to writable bits
    function automatic logic [31:0] putByte(
        input logic [31:0] r,
        input logic [1:0] lane,
        input logic [7:0] d,
        input logic [31:0] m
    );
        logic [31:0] laneMask;
        logic [31:0] shifted;
        laneMask = 32'h0000_00FF << {lane, 3'b000};
        shifted = {24'h00_0000, d} << {lane, 3'b000};
        return (r & ~(m & laneMask)) | (shifted & m & laneMask);
    endfunction : putByte

    // Byte lane read
    function automatic logic [7:0] getByte(
        input logic [31:0] r,
        input logic [1:0] lane
    );
        logic [31:0] shifted;
        shifted = r >> {lane, 3'b000};
        return shifted[7:0];
    endfunction : getByte

    // Result first, then chain id, then high and low supply flags
    function automatic logic [37:0] buildFrame(
        input logic [15:0] res,
        input logic [3:0] id,
        input logic idEn,
        input logic [1:0] sup,
        input logic hi,
        input logic lo
    );
        logic [31:0] w;
        int unsigned n;
        w = {res, 16'h0000};
        n = aoc_pkg::RESULT_W;
        if (idEn) begin
            w[31 - n -: 4] = id;
            n = n + aoc_pkg::CHAIN_W;
        end
        if (sup[0]) begin
            w[31 - n] = hi;
            n = n + 1;
        end
        if (sup[1]) begin
            w[31 - n] = lo;
            n = n + 1;
        end
        return {6'(n), w};
    endfunction : buildFrame

    // ************************************************************
    // Register bank
    // ************************************************************

    logic [31:0] id_q, id_d, proto_q, proto_d;
    logic [31:0] content_q, content_d;
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;
    logic [7:0] wordAddr;
    logic [1:0] byteLane;

    assign wordAddr = {regAddr[7:2], 2'b00};
    assign byteLane = regAddr[1:0];

    // Decode: each register word owns four ascending byte addresses
    always_comb begin
        id_d = id_q;
        proto_d = proto_q;
        content_d = content_q;
        rdData_d = rdData_q;
        rdValid_d = 1'b0;
        if (regWr) begin
            case (wordAddr)
                aoc_pkg::ID_BASE: begin
                    id_d = putByte(id_q, byteLane, regWrData,
                                   aoc_pkg::ID_WMASK);
                end
                aoc_pkg::PROTO_BASE: begin
                    proto_d = putByte(proto_q, byteLane, regWrData,
                                      aoc_pkg::PROTO_WMASK);
                end
                aoc_pkg::CONTENT_BASE: begin
                    content_d = putByte(content_q, byteLane, regWrData,
                                        aoc_pkg::CONTENT_WMASK);
                end
                default: begin
                    // Unmapped bytes swallow the write
                    id_d = id_q;
                end
            endcase
        end
        if (regRd) begin
            rdValid_d = 1'b1;
            case (wordAddr)
                aoc_pkg::ID_BASE: rdData_d = getByte(id_q, byteLane);
                aoc_pkg::PROTO_BASE: begin
                    rdData_d = getByte(proto_q, byteLane);
                end
                aoc_pkg::CONTENT_BASE: begin
                    rdData_d = getByte(content_q, byteLane);
                end
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // Masks keep reserved storage at zero, so reads return zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            id_q <= aoc_pkg::ID_RST;
            proto_q <= aoc_pkg::PROTO_RST;
            content_q <= aoc_pkg::CONTENT_RST;
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else if (ce) begin
            id_q <= id_d;
            proto_q <= proto_d;
            content_q <= content_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;

    // ************************************************************
    // Mode decode
    // ************************************************************

    aoc_pkg::aoc_lane_e laneFn;
    logic [1:0] outProto;
    logic syncProto, useInternal, fallLaunch;

    assign laneFn = aoc_pkg::aoc_lane_e'(
        proto_q[aoc_pkg::LANE_LSB +: 2]);
    assign outProto = proto_q[aoc_pkg::PROTO_LSB +: 2];
    // Invalid code 10b is treated as the input-side SPI mode
    assign syncProto = (outProto == aoc_pkg::PROTO_SYNC);
    // Clock source bit is dead outside the sync protocol
    assign useInternal = syncProto
        && proto_q[aoc_pkg::SYNC_SRC_BIT];
    // SPI modes 0 and 3 change data on the falling edge
    assign fallLaunch = !syncProto
        && (inputProtocolSelect[1] == inputProtocolSelect[0]);

    // ************************************************************
    // Frame hand-over
    // ************************************************************

    aoc_frame_if fiExt ();
    aoc_frame_if fiInt ();

    logic [31:0] word_q, word_d;
    logic [5:0] len_q, len_d;
    logic two_q, two_d, fall_q, fall_d;
    logic reqExt_q, reqExt_d, reqInt_q, reqInt_d;
    logic [1:0] ackExt_q, ackExt_d, ackInt_q, ackInt_d;
    logic laneBLvl_q, laneBLvl_d;
    logic [37:0] frame;
    logic idle;

    assign frame = buildFrame(convData,
        id_q[aoc_pkg::CHAIN_ID_LSB +: 4],
        content_q[aoc_pkg::CHAIN_APPEND_BIT],
        content_q[aoc_pkg::SUPPLY_LSB +: 2],
        supplyHigh, supplyLow);
    // A conversion arriving while the chosen lane is busy is dropped
    assign idle = useInternal ? (ackInt_q[1] == reqInt_q)
                              : (ackExt_q[1] == reqExt_q);

    // Latch the frame and toggle the chosen serializer's request
    always_comb begin
        word_d = word_q;
        len_d = len_q;
        two_d = two_q;
        fall_d = fall_q;
        reqExt_d = reqExt_q;
        reqInt_d = reqInt_q;
        ackExt_d = {ackExt_q[0], fiExt.ack};
        ackInt_d = {ackInt_q[0], fiInt.ack};
        if (convValid && idle) begin
            word_d = frame[31:0];
            len_d = frame[37:32];
            two_d = (laneFn == aoc_pkg::LANE_DATA);
            fall_d = fallLaunch;
            if (useInternal) begin
                reqInt_d = ~reqInt_q;
            end else begin
                reqExt_d = ~reqExt_q;
            end
        end
        // Static second-lane levels come from this clock
        laneBLvl_d = (laneFn == aoc_pkg::LANE_ALARM) ? alarmActive
            : proto_q[aoc_pkg::GPO_BIT];
    end

    // Hand-over registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_q <= 32'h0000_0000;
            len_q <= 6'h00;
            two_q <= 1'b0;
            fall_q <= 1'b0;
            reqExt_q <= 1'b0;
            reqInt_q <= 1'b0;
            ackExt_q <= 2'b00;
            ackInt_q <= 2'b00;
            laneBLvl_q <= 1'b0;
        end else if (ce) begin
            word_q <= word_d;
            len_q <= len_d;
            two_q <= two_d;
            fall_q <= fall_d;
            reqExt_q <= reqExt_d;
            reqInt_q <= reqInt_d;
            ackExt_q <= ackExt_d;
            ackInt_q <= ackInt_d;
            laneBLvl_q <= laneBLvl_d;
        end
    end

    assign fiExt.word = word_q;
    assign fiExt.len = len_q;
    assign fiExt.twoLane = two_q;
    assign fiExt.fallLaunch = fall_q;
    assign fiExt.req = reqExt_q;
    assign fiInt.word = word_q;
    assign fiInt.len = len_q;
    assign fiInt.twoLane = two_q;
    assign fiInt.fallLaunch = fall_q;
    assign fiInt.req = reqInt_q;

    // ************************************************************
    // Lanes
    // ************************************************************

    logic extA, extB, extOe, intA, intB, intOe;

    // Host serial clock side; the link clock has no enable of its own
    aoc_lane_serializer #(.SYNC_SEL(1'b0)) u_extLane (
        .clk(linkClk),
        .rst(rst),
        .ce(1'b1),
        .frameSelN(frameSelN),
        .fi(fiExt.snk),
        .laneA(extA),
        .laneB(extB),
        .laneOe(extOe)
    );

    // Internal clock side, frame select synchronised inside
    aoc_lane_serializer #(.SYNC_SEL(1'b1)) u_intLane (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .frameSelN(frameSelN),
        .fi(fiInt.snk),
        .laneA(intA),
        .laneB(intB),
        .laneOe(intOe)
    );

    // Pin selection is static configuration, so no glitch mid-frame
    assign serialOutLaneA = useInternal ? intA : extA;
    assign serialOutLaneAOe = useInternal ? intOe : extOe;
    assign serialOutLaneB = (laneFn == aoc_pkg::LANE_DATA)
        ? (useInternal ? intB : extB) : laneBLvl_q;
    assign serialOutLaneBOe = (laneFn == aoc_pkg::LANE_OFF) ? 1'b0
        : (laneFn == aoc_pkg::LANE_DATA) ? serialOutLaneAOe
        : 1'b1;

    // ************************************************************
    // Checks
    // ************************************************************

    property p_protoMap;
        @(posedge ref_clk) disable iff (rst)
        ce && regWr && regAddr == aoc_pkg::PROTO_BASE + 8'h01
            |=> proto_q[15:8] == ($past(regWrData)
                & aoc_pkg::PROTO_WMASK[15:8]);
    endproperty
    a_protoMap: assert property (p_protoMap)
        else $error("protocol byte 1 not written at 0Dh");

    property p_contentRead;
        @(posedge ref_clk) disable iff (rst)
        ce && regRd && regAddr == aoc_pkg::CONTENT_BASE + 8'h01
            |=> regRdValid && regRdData == $past(content_q[15:8]);
    endproperty
    a_contentRead: assert property (p_contentRead)
        else $error("content byte 1 not read at 11h");

    property p_reservedZero;
        @(posedge ref_clk) disable iff (rst)
        ((proto_q & ~aoc_pkg::PROTO_WMASK) == 32'h0000_0000)
            && ((content_q & ~aoc_pkg::CONTENT_WMASK) == 32'h0000_0000);
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved bit holds a one");

    property p_laneOff;
        @(posedge ref_clk) disable iff (rst)
        laneFn == aoc_pkg::LANE_OFF |-> !serialOutLaneBOe;
    endproperty
    a_laneOff: assert property (p_laneOff)
        else $error("second lane driven while off");

    property p_gpoLane;
        @(posedge ref_clk) disable iff (rst)
        ce && laneFn == aoc_pkg::LANE_GPO ##1 laneFn == aoc_pkg::LANE_GPO
            |-> serialOutLaneBOe
                && serialOutLaneB == $past(proto_q[aoc_pkg::GPO_BIT]);
    endproperty
    a_gpoLane: assert property (p_gpoLane)
        else $error("general output level not on second lane");

    property p_alarmLane;
        @(posedge ref_clk) disable iff (rst)
        ce && laneFn == aoc_pkg::LANE_ALARM
            ##1 laneFn == aoc_pkg::LANE_ALARM
            |-> serialOutLaneB == $past(alarmActive);
    endproperty
    a_alarmLane: assert property (p_alarmLane)
        else $error("alarm not on second lane");

    property p_frameLen;
        @(posedge ref_clk) disable iff (rst)
        $changed(reqExt_q) || $changed(reqInt_q)
            |-> len_q == 6'h10
                + ($past(content_q[14]) ? 6'h04 : 6'h00)
                + {5'h00, $past(content_q[12])}
                + {5'h00, $past(content_q[13])};
    endproperty
    a_frameLen: assert property (p_frameLen)
        else $error("frame length does not match appended fields");

    property p_chainId;
        @(posedge ref_clk) disable iff (rst)
        ($changed(reqExt_q) || $changed(reqInt_q))
            && $past(content_q[14])
            |-> word_q[15:12] == $past(id_q[19:16]);
    endproperty
    a_chainId: assert property (p_chainId)
        else $error("chain id not placed after the result");

endmodule : aoc_output_config_regs

// ===== test/aoc_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host controller that clocks frames out of the lanes
// ****************************************************************
module aoc_host_model (
    output logic linkClk,
    output logic frameSelN,
    input wire logic laneA,
    input wire logic laneB
);
    // Clock idles low and select stays high between frames
    initial begin
        linkClk = 1'b0;
        frameSelN = 1'b1;
    end

    // Preload edges first; the serializer needs them to sync the word
    task automatic frame(input int n, input bit two,
                         output logic [31:0] got);
        got = 32'h0;
        repeat (8) begin
            #32 linkClk = 1'b1;
            #32 linkClk = 1'b0;
        end
        frameSelN = 1'b0;
        // Polarity 0, phase 0: sample on rising edge
        repeat (n) begin
            #32 linkClk = 1'b1;
            got = two ? {got[29:0], laneA, laneB}
                      : {got[30:0], laneA};
            #32 linkClk = 1'b0;
        end
        #32 frameSelN = 1'b1;
    endtask : frame
endmodule : aoc_host_model

// ===== test/aoc_output_config_regs_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Register and frame bench
// ****************************************************************
module aoc_output_config_regs_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic regWr = 1'b0, regRd = 1'b0, convValid = 1'b0, alarm = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
    logic [15:0] convData = 16'h0046;
    logic [7:0] regRdData;
    logic regRdValid, laneA, laneAOe, laneB, laneBOe, linkClk, selN;
    logic [7:0] expQ[$];
    logic [31:0] got;
    logic [7:0] mask[8] = '{8'h43, 8'h13, 0, 0, 0, 8'h70, 0, 0};
    int num_errors = 0, total_checks = 0, cyc = 0;

    initial forever #5 ref_clk = ~ref_clk;

    aoc_output_config_regs i_aoc_output_config_regs (.ref_clk(ref_clk),
        .rst(rst), .ce(ce), .linkClk(linkClk), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .inputProtocolSelect(2'h0), .convData(convData),
        .convValid(convValid), .alarmActive(alarm), .supplyHigh(1'b0),
        .supplyLow(1'b0), .frameSelN(selN), .serialOutLaneA(laneA),
        .serialOutLaneAOe(laneAOe), .serialOutLaneB(laneB),
        .serialOutLaneBOe(laneBOe));
    aoc_host_model i_aoc_host_model (.linkClk(linkClk),
        .frameSelN(selN), .laneA(laneA), .laneB(laneB));

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask : chk

    // Strobes rise and fall on falling edges, one idle cycle between
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk) {regWr, regAddr, regWrData} = {1'b1, a, d};
        @(negedge ref_clk) regWr = 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge ref_clk) {regRd, regAddr} = {1'b1, a};
        expQ.push_back(e);
        @(negedge ref_clk) regRd = 1'b0;
    endtask : rd

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Read watcher: valid lasts one cycle, so look at falling edges
    always @(negedge ref_clk) begin
        if (regRdValid === 1'b1 && expQ.size() > 0) begin
            chk("regRdData", {24'h0, expQ.pop_front()},
                {24'h0, regRdData});
        end
    end

    // Cut a hang short; the full run needs far fewer cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end

    // Lane B settles through one flop after the write
    task automatic laneb(logic [7:0] d, logic [1:0] e);
        wr(8'h0D, d);
        repeat (3) @(negedge ref_clk);
        chk("laneB", {30'h0, e}, {30'h0, laneBOe, laneB});
    endtask : laneb

    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        rd(8'h02, 8'h01);
        // A write while the enable is low must not land
        ce = 1'b0;
        wr(8'h0C, 8'h01);
        ce = 1'b1;
        rd(8'h0C, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd(8'(12 + i), 8'h00);
            rd(8'(16 + i), 8'h00);
        end
        // All ones into every protocol and content byte, then only writable bits come back
        for (int i = 0; i < 8; i++) begin
            wr(8'(12 + i), 8'hFF);
            rd(8'(12 + i), mask[i]);
        end
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        laneb(8'h00, 2'b00);
        alarm = 1'b1;
        laneb(8'h01, 2'b11);
        alarm = 1'b0;
        laneb(8'h01, 2'b10);
        laneb(8'h12, 2'b11);
        laneb(8'h02, 2'b10);
        wr(8'h0C, 8'h00);
        wr(8'h0D, 8'h00);
        wr(8'h02, 8'h0A);
        // Chain id on the first frame only; the third uses both lanes
        for (int k = 0; k < 3; k++) begin
            wr(8'h11, k == 0 ? 8'h40 : 8'h00);
            if (k == 2) wr(8'h0D, 8'h03);
            @(negedge ref_clk) {convValid, convData} = {1'b1, lfsr(convData)};
            @(negedge ref_clk) convValid = 1'b0;
            repeat (4) @(negedge ref_clk);
            i_aoc_host_model.frame(k == 0 ? 20 : k == 1 ? 16 : 8, k == 2, got);
            chk("frame", k == 0 ? {12'h0, convData, 4'hA}
                : {16'h0, convData}, got);
            // Lane A enable must drop once the frame length is sent
            chk("laneAOe", 32'h0, {31'h0, laneAOe});
        end
        results();
    end
endmodule : aoc_output_config_regs_tb
